// ---- verilog/timer8_pkg.sv ----
// Purpose: Shared constants of the 8-bit compare timer
// Assumes: Classic Wishbone, 32-bit data, word aligned registers
// Notes: Register layout and offsets are local to this block
package timer8_pkg;
   typedef logic [1:0] mode_t;
   typedef logic [1:0] com_t;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_COUNT = 4'h4;
   localparam logic [3:0] OFS_COMPARE = 4'h8;
   localparam logic [3:0] OFS_FLAGS = 4'hc;
   localparam int MODE_LSB = 0;
   localparam int COM_LSB = 2;
   localparam int FORCE_BIT = 7;
   localparam int OVF_BIT = 0;
   localparam int MATCH_BIT = 1;
   localparam mode_t MODE_NORMAL = 2'h0;
   localparam mode_t MODE_PC_PWM = 2'h1;
   localparam mode_t MODE_CLEAR = 2'h2;
   localparam mode_t MODE_FAST_PWM = 2'h3;
   localparam com_t COM_OFF = 2'h0;
   localparam com_t COM_TOGGLE = 2'h1;
   localparam com_t COM_CLEAR = 2'h2;
   localparam com_t COM_SET = 2'h3;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COMPARE_RST = 8'h00;
   localparam logic OUT_RST = 1'b0;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;

   function automatic logic is_pwm(input mode_t m);
      return (m == MODE_PC_PWM) || (m == MODE_FAST_PWM);
   endfunction
endpackage

// ---- verilog/compare_store.sv ----
// Purpose: Live compare value with its optional buffer
// Assumes: Load pulse comes at the top of a PWM sequence
// Notes: Readback shows the register that the CPU reaches
`timescale 1ns/1ps
module compare_store
   import timer8_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic wr,
   input wire logic [W-1:0] wdata,
   input wire logic buffered,
   input wire logic load,
   output logic [W-1:0] live_q,
   output logic [W-1:0] shadow_q
);
   logic [W-1:0] live_d;
   logic [W-1:0] shadow_d;

   always_comb begin
      live_d = live_q;
      shadow_d = shadow_q;
      if (buffered && load) begin
         live_d = shadow_q;
      end
      if (wr) begin
         shadow_d = wdata;
         if (!buffered) begin
            live_d = wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         live_q <= W'(COMPARE_RST);
         shadow_q <= W'(COMPARE_RST);
      end else begin
         live_q <= live_d;
         shadow_q <= shadow_d;
      end
   end
endmodule // compare_store

// ---- verilog/compare_output.sv ----
// Purpose: Compare output register and pin source select
// Assumes: Port data and direction come from same-clock port logic
// Notes: Enable is low while the pin is driven
`timescale 1ns/1ps
module compare_output
   import timer8_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic event_hit,
   input wire com_t com,
   input wire logic port_dir,
   input wire logic port_data,
   output logic oc_q,
   output logic pin_out_q,
   output logic pin_oe_n_q
);
   logic oc_d;
   logic pin_out_d;
   logic pin_oe_n_d;

   always_comb begin
      oc_d = oc_q;
      if (event_hit) begin
         unique case (com)
            COM_TOGGLE: oc_d = !oc_q;
            COM_CLEAR: oc_d = 1'b0;
            COM_SET: oc_d = 1'b1;
            COM_OFF: oc_d = oc_q;
         endcase
      end
      pin_out_d = (com != COM_OFF) ? oc_d : port_data;
      pin_oe_n_d = !port_dir;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         oc_q <= OUT_RST;
         pin_out_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else begin
         oc_q <= oc_d;
         pin_out_q <= pin_out_d;
         pin_oe_n_q <= pin_oe_n_d;
      end
   end
endmodule // compare_output

// ---- verilog/timer8_compare_output_ctc.sv ----
// Purpose: 8-bit timer with compare output, normal, clear-on-match, fast PWM and phase-correct PWM
// Assumes: timer_tick is a one-cycle enable from same-clock prescaler
// Notes: Registers on classic Wishbone, one wait state per access
`timescale 1ns/1ps
module timer8_compare_output_ctc
   import timer8_pkg::*;
#(
   parameter int CW = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic timer_tick,
   input wire logic ovf_service,
   input wire logic match_service,
   input wire logic port_dir,
   input wire logic port_data,
   output logic compare_output,
   output logic pin_out,
   output logic pin_oe_n,
   output logic overflow_flag,
   output logic compare_match_flag
);
   if (CW != 8) begin : g_width_check
      $error("timer8_compare_output_ctc supports only an 8-bit counter");
   end

   // Bus state
   logic ack_d;
   logic [31:0] rdat_d;
   logic [31:0] rdat_q;
   logic ack_q;

   // Control state
   mode_t mode_d;
   mode_t mode_q;
   com_t com_d;
   com_t com_q;

   // Counter state
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] cnt_q;
   logic down_d;
   logic down_q;
   logic blk_d;
   logic blk_q;
   logic ovf_d;
   logic ovf_q;
   logic mf_d;
   logic mf_q;

   // Decoded strobes
   logic req;
   logic wr_go;
   logic lane0;
   logic ctrl_wr;
   logic cnt_wr;
   logic cmp_wr;
   logic flag_wr;
   logic frc_go;
   logic hit;
   logic equal;
   logic ovf_set;
   logic load_top;
   logic out_event;
   logic [CW-1:0] live_w;
   logic [CW-1:0] shadow_w;
   logic oc_w;
   logic [31:0] rd_val;

   // Bus decode: a write lands on the edge that the master sees ack
   assign req = wb_cyc_i && wb_stb_i;
   assign wr_go = req && wb_we_i && ack_q;
   assign lane0 = wb_sel_i[0];
   assign ctrl_wr = wr_go && lane0 && (wb_adr_i == OFS_CTRL);
   assign cnt_wr = wr_go && lane0 && (wb_adr_i == OFS_COUNT);
   assign cmp_wr = wr_go && lane0 && (wb_adr_i == OFS_COMPARE);
   assign flag_wr = wr_go && lane0 && (wb_adr_i == OFS_FLAGS);
   // Force only in non-PWM modes, judged on the mode being written
   assign frc_go = ctrl_wr && wb_dat_i[FORCE_BIT]
      && !is_pwm(wb_dat_i[MODE_LSB +: 2]);

   // Compare and match
   assign equal = (cnt_q == live_w);
   assign hit = timer_tick && equal && !blk_q;
   assign out_event = hit || frc_go;
   assign load_top = timer_tick && is_pwm(mode_q) && (cnt_q == COUNT_MAX);

   always_comb begin
      rd_val = 32'h0;
      unique case (wb_adr_i)
         OFS_CTRL: rd_val[7:0] = {4'h0, com_q, mode_q};
         OFS_COUNT: rd_val[7:0] = cnt_q;
         OFS_COMPARE: rd_val[7:0] = is_pwm(mode_q) ? shadow_w : live_w;
         OFS_FLAGS: rd_val[7:0] = {6'h0, mf_q, ovf_q};
         default: rd_val = 32'h0;
      endcase
   end

   always_comb begin
      ack_d = req && !ack_q;
      rdat_d = (req && !ack_q && !wb_we_i) ? rd_val : 32'h0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // Control register
   always_comb begin
      mode_d = mode_q;
      com_d = com_q;
      if (ctrl_wr) begin
         mode_d = wb_dat_i[MODE_LSB +: 2];
         com_d = wb_dat_i[COM_LSB +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mode_q <= MODE_NORMAL;
         com_q <= COM_OFF;
      end else begin
         mode_q <= mode_d;
         com_q <= com_d;
      end
   end

   // Overflow: roll from max to zero, or bottom reached counting down
   always_comb begin
      if (mode_q == MODE_PC_PWM) begin
         ovf_set = timer_tick && !cnt_wr && down_q
            && (cnt_q == COUNT_BOTTOM + 8'h01);
      end else begin
         ovf_set = timer_tick && !cnt_wr && (cnt_q == COUNT_MAX);
      end
   end

   // Counter, direction, blocking and flags
   always_comb begin
      cnt_d = cnt_q;
      down_d = down_q;
      blk_d = blk_q;
      ovf_d = ovf_q;
      mf_d = mf_q;
      if (timer_tick) begin
         blk_d = 1'b0;
         unique case (mode_q)
            MODE_NORMAL: cnt_d = cnt_q + 8'h01;
            MODE_FAST_PWM: cnt_d = cnt_q + 8'h01;
            MODE_CLEAR: begin
               // Compare is the top; a top below the count wraps first
               if (hit) begin
                  cnt_d = COUNT_BOTTOM;
               end else begin
                  cnt_d = cnt_q + 8'h01;
               end
            end
            MODE_PC_PWM: begin
               if (!down_q && cnt_q == COUNT_MAX) begin
                  down_d = 1'b1;
                  cnt_d = cnt_q - 8'h01;
               end else if (down_q && cnt_q == COUNT_BOTTOM) begin
                  down_d = 1'b0;
                  cnt_d = cnt_q + 8'h01;
               end else begin
                  cnt_d = down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
               end
            end
         endcase
      end
      if (cnt_wr) begin
         cnt_d = wb_dat_i[CW-1:0];
         blk_d = 1'b1;
      end
      // Clears first so that a set in the same cycle wins
      if (ovf_service || (flag_wr && wb_dat_i[OVF_BIT])) begin
         ovf_d = 1'b0;
      end
      if (ovf_set) begin
         ovf_d = 1'b1;
      end
      if (match_service || (flag_wr && wb_dat_i[MATCH_BIT])) begin
         mf_d = 1'b0;
      end
      if (hit) begin
         mf_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= COUNT_RST;
         down_q <= 1'b0;
         blk_q <= 1'b0;
         ovf_q <= 1'b0;
         mf_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         down_q <= down_d;
         blk_q <= blk_d;
         ovf_q <= ovf_d;
         mf_q <= mf_d;
      end
   end

   compare_store #(
      .W(CW)
   ) u_store (
      .clk(clk),
      .reset(reset),
      .wr(cmp_wr),
      .wdata(wb_dat_i[CW-1:0]),
      .buffered(is_pwm(mode_q)),
      .load(load_top),
      .live_q(live_w),
      .shadow_q(shadow_w)
   );

   compare_output u_out (
      .clk(clk),
      .reset(reset),
      .event_hit(out_event),
      .com(com_d),
      .port_dir(port_dir),
      .port_data(port_data),
      .oc_q(oc_w),
      .pin_out_q(pin_out),
      .pin_oe_n_q(pin_oe_n)
   );

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign compare_output = oc_w;
   assign overflow_flag = ovf_q;
   assign compare_match_flag = mf_q;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_direct_compare: assert property (
      cmp_wr && !is_pwm(mode_q) |=> live_w == $past(wb_dat_i[CW-1:0]))
      else $error("Unbuffered compare write did not reach live value");

   a_force_no_flag: assert property (
      frc_go && !hit && !mf_q |=> !mf_q)
      else $error("Forced compare set the match flag");

   a_force_no_count: assert property (
      frc_go && !timer_tick && !cnt_wr |=> cnt_q == $past(cnt_q))
      else $error("Forced compare changed the counter");

   a_write_blocks: assert property (
      cnt_wr ##1 (timer_tick && equal) |-> !hit)
      else $error("Match not blocked after counter write");

   a_reset_out_low: assert property (
      $past(reset) |-> !oc_w)
      else $error("Output register not zero after reset");

   a_mode_at_once: assert property (
      ctrl_wr |=> com_q == $past(wb_dat_i[COM_LSB +: 2]))
      else $error("Output mode write did not act at once");

   a_clear_on_top: assert property (
      hit && mode_q == MODE_CLEAR && !cnt_wr |=> cnt_q == COUNT_BOTTOM)
      else $error("Counter not cleared at compare top");

   a_flag_follows: assert property (
      hit |=> mf_q ##0 $past(equal))
      else $error("Match flag did not set after equal compare");

   a_toggle_out: assert property (
      out_event && com_d == COM_TOGGLE |=> oc_w != $past(oc_w))
      else $error("Toggle mode did not invert the output");

   a_ovf_on_roll: assert property (
      timer_tick && !cnt_wr && cnt_q == COUNT_MAX && !is_pwm(mode_q)
      |=> ovf_q && cnt_q == COUNT_BOTTOM)
      else $error("Overflow flag missing on roll to zero");

   a_write_wins: assert property (
      cnt_wr |=> cnt_q == $past(wb_dat_i[CW-1:0]))
      else $error("Counter write lost to count or clear");

   a_pin_gated: assert property (
      !port_dir |=> pin_oe_n)
      else $error("Pin driven while direction is input");

   a_oe_follows_dir: assert property (
      port_dir |=> !pin_oe_n)
      else $error("Pin not driven while direction is output");

   a_pin_source: assert property (
      com_d != COM_OFF |=> pin_out == oc_w)
      else $error("Pin does not show the compare output");

   a_pin_from_port: assert property (
      com_d == COM_OFF |=> pin_out == $past(port_data))
      else $error("Pin does not show the port value");

   a_force_pwm_off: assert property (
      ctrl_wr && wb_dat_i[FORCE_BIT] && is_pwm(wb_dat_i[MODE_LSB +: 2]) && !hit
      |=> oc_w == $past(oc_w))
      else $error("Forced compare acted in a PWM mode");

   a_ovf_only_set: assert property (
      !ovf_q && !ovf_set |=> !ovf_q)
      else $error("Overflow flag set without a roll");

   a_match_clears: assert property (
      (match_service || (flag_wr && wb_dat_i[MATCH_BIT])) && !hit |=> !mf_q)
      else $error("Match flag not cleared");

   a_buffer_load: assert property (
      load_top |=> live_w == $past(shadow_w))
      else $error("Buffer not loaded into live compare at top");

   a_buffer_holds: assert property (
      cmp_wr && is_pwm(mode_q) && !load_top |=> live_w == $past(live_w))
      else $error("Buffered compare write reached live value");

   a_ctc_count_on: assert property (
      timer_tick && !hit && !cnt_wr && mode_q == MODE_CLEAR
      |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("Counter did not count on without a match");

   a_force_reads_zero: assert property (
      req && !wb_we_i && !ack_q && wb_adr_i == OFS_CTRL |=> !wb_dat_o[FORCE_BIT])
      else $error("Force strobe did not read as zero");

   c_ctc_match: cover property (hit && mode_q == MODE_CLEAR);
   c_force: cover property (frc_go && com_d == COM_TOGGLE);
   c_buffer_load: cover property (load_top);
   c_overflow: cover property ($rose(ovf_q));
   c_blocked: cover property (timer_tick && equal && blk_q);
endmodule // timer8_compare_output_ctc

// ---- sim/timer8_compare_output_ctc_tb.sv ----
// Purpose: Self-checking bench of the 8-bit compare timer
// Assumes: Each bus access is answered one cycle after it is taken
// Notes: Timer ticks are driven by hand, one cycle wide except in t_write, held over a counter write
`timescale 1ns/1ps
module timer8_compare_output_ctc_tb
   import timer8_pkg::*;
;
   logic clk, reset, cyc, stb, we, timer_tick, ovf_service, match_service, port_dir, port_data;
   logic [3:0] adr, sel;
   logic [31:0] dat_i, dat_o, rdata;
   logic ack, oc, pin_out, pin_oe_n, ovf, mf;
   logic [3:0] lanes;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;

   timer8_compare_output_ctc #(.CW(8)) i_timer8_compare_output_ctc (
      .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .timer_tick(timer_tick), .ovf_service(ovf_service), .match_service(match_service),
      .port_dir(port_dir), .port_data(port_data), .compare_output(oc), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .overflow_flag(ovf), .compare_match_flag(mf)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] ctrl(input mode_t m, input com_t c, input logic f);
      return {24'h0, f, 3'h0, c, m};
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Cycle ceiling against a hang
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
      end
   endtask

   // Classic single Wishbone cycle, held until ack
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= lanes;
      dat_i <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      check(n, 32'h2, "bus answer one cycle after taken");
      rdata = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(rdata, exp, what);
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         @(posedge clk);
         timer_tick <= 1'b1;
         @(posedge clk);
         timer_tick <= 1'b0;
      end
      #1;
   endtask

   task automatic service(input logic on_ovf);
      @(posedge clk);
      if (on_ovf) ovf_service <= 1'b1;
      else match_service <= 1'b1;
      @(posedge clk);
      ovf_service <= 1'b0;
      match_service <= 1'b0;
      #1;
   endtask

   task automatic t_reset;
      #1;
      check(oc, 1'b0, "output after reset");
      check({ovf, mf}, 2'h0, "flags after reset");
      check(pin_oe_n, 1'b1, "pin enable after reset");
      for (int a = 0; a < 4; a++) rd(4'(a * 4), 32'h0, "register after reset");
      rd(4'h2, 32'h0, "unmapped read");
   endtask

   task automatic t_force;
      port_data <= 1'b0;
      wr(OFS_CTRL, ctrl(MODE_NORMAL, COM_TOGGLE, 1'b1));
      port_dir <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check(oc, 1'b1, "forced toggle");
      check(mf, 1'b0, "flag after force");
      check(pin_out, 1'b1, "pin from compare");
      check(pin_oe_n, 1'b0, "pin driven");
      rd(OFS_CTRL, ctrl(MODE_NORMAL, COM_TOGGLE, 1'b0), "force reads zero");
      rd(OFS_COUNT, 32'h0, "count after force");
      wr(OFS_CTRL, ctrl(MODE_CLEAR, COM_OFF, 1'b0));
      repeat (2) @(posedge clk);
      #1;
      check(oc, 1'b1, "output kept over mode change");
      check(pin_out, 1'b0, "pin from port logic");
   endtask

   task automatic t_ctc;
      wr(OFS_COMPARE, 32'h3);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL, ctrl(MODE_CLEAR, COM_TOGGLE, 1'b0));
      tick(3);
      check(mf, 1'b0, "no match before top");
      check(oc, 1'b1, "no toggle before top");
      tick(1);
      check(mf, 1'b1, "match at top");
      check(oc, 1'b0, "toggle at top");
      rd(OFS_COUNT, 32'h0, "count cleared at top");
      wr(OFS_FLAGS, 32'h2);
      #1;
      check(mf, 1'b0, "flag cleared by one");
      tick(4);
      check(oc, 1'b1, "half period of one plus compare");
      service(1'b0);
      check(mf, 1'b0, "flag cleared by service");
   endtask

   task automatic t_block;
      wr(OFS_CTRL, ctrl(MODE_CLEAR, COM_OFF, 1'b0));
      wr(OFS_COUNT, 32'h3);
      wr(OFS_CTRL, ctrl(MODE_CLEAR, COM_TOGGLE, 1'b0));
      repeat (5) @(posedge clk);
      tick(1);
      check(mf, 1'b0, "match blocked after count write");
      check(oc, 1'b1, "output held when blocked");
      rd(OFS_COUNT, 32'h4, "count after blocked tick");
      wr(OFS_COMPARE, 32'h2);
      tick(251);
      check(ovf, 1'b0, "no overflow before wrap");
      tick(1);
      check(ovf, 1'b1, "overflow on wrap");
      check(mf, 1'b0, "no match before wrap");
      rd(OFS_FLAGS, 32'h1, "flags after wrap");
      service(1'b1);
      check(ovf, 1'b0, "overflow cleared by service");
      tick(2);
      check(mf, 1'b0, "no match below compare");
      tick(1);
      check(mf, 1'b1, "match after wrap");
   endtask

   task automatic t_write;
      wr(OFS_CTRL, ctrl(MODE_NORMAL, COM_TOGGLE, 1'b0));
      @(posedge clk);
      timer_tick <= 1'b1;
      wr(OFS_COUNT, 32'h40);
      timer_tick <= 1'b0;
      rd(OFS_COUNT, 32'h40, "write wins over count");
      lanes = 4'he;
      wr(OFS_COUNT, 32'h11);
      lanes = 4'hf;
      rd(OFS_COUNT, 32'h40, "write without lane zero ignored");
   endtask

   task automatic t_buffer;
      logic held;
      wr(OFS_CTRL, ctrl(MODE_FAST_PWM, COM_OFF, 1'b0));
      wr(OFS_COMPARE, 32'h20);
      rd(OFS_COMPARE, 32'h20, "buffer reached in pwm");
      wr(OFS_CTRL, ctrl(MODE_NORMAL, COM_OFF, 1'b0));
      rd(OFS_COMPARE, 32'h2, "live compare not loaded");
      wr(OFS_COMPARE, 32'h30);
      rd(OFS_COMPARE, 32'h30, "live compare written");
      wr(OFS_CTRL, ctrl(MODE_FAST_PWM, COM_OFF, 1'b0));
      wr(OFS_COMPARE, 32'h50);
      wr(OFS_COUNT, 32'hff);
      tick(1);
      held = oc;
      wr(OFS_CTRL, ctrl(MODE_PC_PWM, COM_TOGGLE, 1'b1));
      repeat (2) @(posedge clk);
      #1;
      check(oc, held, "force ignored in pwm");
      wr(OFS_CTRL, ctrl(MODE_NORMAL, COM_OFF, 1'b0));
      rd(OFS_COMPARE, 32'h50, "buffer loaded at top");
   endtask

   task automatic t_rst_mid;
      wr(OFS_CTRL, ctrl(MODE_NORMAL, COM_SET, 1'b1));
      @(posedge clk);
      #1;
      check(oc, 1'b1, "forced set");
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1;
      check(oc, 1'b0, "output after mid-run reset");
      check(pin_out, 1'b0, "pin after mid-run reset");
      rd(OFS_CTRL, 32'h0, "control after mid-run reset");
   endtask

   initial begin
      reset = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      sel = 4'hf;
      lanes = 4'hf;
      dat_i = 32'h0;
      timer_tick = 1'b0;
      ovf_service = 1'b0;
      match_service = 1'b0;
      port_dir = 1'b0;
      port_data = 1'b0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_force();
      t_ctc();
      t_block();
      t_write();
      t_buffer();
      t_rst_mid();
      complete_run();
   end
endmodule // timer8_compare_output_ctc_tb
